/* src/pwm_deadband.sv */
// dead band counter: done pulses len cycles after start
`timescale 1ns/1ps
`default_nettype none
`include "pwm_out_consts.svh"

module pwm_deadband (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control
   input  wire logic       start,
   input  wire logic       cancel,
   input  wire logic [7:0] len,
   // status
   output logic            done,
   output logic            busy
);

   pwm_out_pkg::db_s st;
   pwm_out_pkg::db_s next_st;

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (st.busy) begin
         next_st.cnt = st.cnt - 8'h01;
         if (st.cnt == 8'h01) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end
      end
      if (start) begin
         next_st.cnt = len;
         next_st.busy = (len != 8'h00);
         next_st.done = 1'b0;
      end else if (cancel) begin
         next_st.busy = 1'b0;
         next_st.done = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done = st.done;
   assign busy = st.busy;

endmodule
`default_nettype wire

/* src/pwm_event_select.sv */
// ors the time base event and the synchronised pin edge, each gated by its select bit
`timescale 1ns/1ps
`default_nettype none
`include "pwm_out_consts.svh"

module pwm_event_select (
   // sources
   input  wire logic       tb_evt,
   input  wire logic       pin_evt,
   // selection
   input  wire logic [7:0] source_sel,
   // result
   output logic            evt
);

   assign evt = (source_sel[`SRC_TB_BIT] & tb_evt) | (source_sel[`SRC_PIN_BIT] & pin_evt);

endmodule
`default_nettype wire

/* src/pwm_out_consts.svh */
// bit positions, field values and reset values of the pwm output stage
`ifndef PWM_OUT_CONSTS_SVH
`define PWM_OUT_CONSTS_SVH

// main control register fields
`define CTL_EN_BIT      7
`define CTL_LD_BIT      6
`define CTL_RDB_BIT     5
`define CTL_FDB_BIT     4
`define CTL_MODE_MSB    3
`define CTL_MODE_LSB    0

// mode field codes
`define MODE_SINGLE     4'h0
`define MODE_COMPL      4'h1
`define MODE_PUSHPULL   4'h2

// event source select bits
`define SRC_TB_BIT      0
`define SRC_PIN_BIT     1

// output bit positions
`define OUT_A           0
`define OUT_B           1
`define OUT_C           2
`define OUT_D           3
`define OUT_E           4
`define OUT_F           5

// reset values
`define RST_BYTE        8'h00
`define RST_OUT6        6'h00
`define RST_MODE        4'h0

`endif

/* src/pwm_out_pkg.sv */
// types shared by the pwm output stage modules
`default_nettype none
package pwm_out_pkg;

   typedef struct packed {
      logic       en;
      logic       rdb_en;
      logic       fdb_en;
      logic [3:0] mode;
   } ctl_s;

   typedef struct packed {
      logic [7:0] cnt;
      logic       busy;
      logic       done;
   } db_s;

   typedef struct packed {
      ctl_s       ctl;
      logic [5:0] steer_act;
      logic [7:0] dbr_act;
      logic [7:0] dbf_act;
      logic       load_pend;
      logic       prim;
      logic       comp;
      logic       pp_a;
      logic       pp_b;
      logic       pp_odd;
      logic       first_per;
      logic       sync1;
      logic       sync2;
      logic       ext_prev;
      logic [5:0] pin_out;
      logic [5:0] pin_oe;
   } stage_s;

endpackage
`default_nettype wire

/* src/pwm_output_stage.sv */
// pwm output stage: event to pin waveform shaping for six outputs
//
// Functional notes
// R1 - each output pin has its own enable
// R2 - disabled output: pin not driven at all
// R3 - enabled output carries the pwm waveform
// R4 - steerable modes drive only steered outputs
// R5 - enabled but unsteered output holds inactive level
// R6 - steering honoured only in steerable modes
// R7 - per output polarity inverts active level
// R8 - waveforms come only from period/rise/fall events
// R9 - mode field sits in main control register
// R10 - enable plus load write copies buffers immediately
// R11 - codes select single, push-pull, complementary with deadbands
// R12 - bit 0 is output a, bit 1 output b
// R13 - each event source independently selectable
// R14 - single mode: no dead band, identical waveforms
// R15 - single: rise sets active, fall sets inactive
// R16 - complementary: primary and opposite complementary waveform
// R17 - primary on a,c,e; complementary on b,d
// R18 - rise: complement off, dead band, primary on
// R19 - fall: primary off, dead band, complement on
// R20 - rise and fall dead bands set independently
// R21 - push-pull alternates a and b, fixed pins
// R22 - odd periods drive a, even periods drive b
// R23 - all timing runs on the module clock
// R24 - buffers load on first period after load
// R25 - push-pull phase toggles; first period is odd
// R26 - disabled module: enabled outputs sit inactive
`timescale 1ns/1ps
`default_nettype none
`include "pwm_out_consts.svh"

module pwm_output_stage (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // main control register write
   input  wire logic       ctrl_wr,
   input  wire logic [7:0] main_control_reg,
   // per output configuration
   input  wire logic [5:0] output_enable_reg,
   input  wire logic [5:0] output_steering_reg,
   input  wire logic [5:0] output_polarity_reg,
   input  wire logic [7:0] rise_deadband_reg,
   input  wire logic [7:0] fall_deadband_reg,
   // event source selection
   input  wire logic [7:0] period_source_reg,
   input  wire logic [7:0] rise_source_reg,
   input  wire logic [7:0] fall_source_reg,
   // events from the time base
   input  wire logic       tb_period,
   input  wire logic       tb_rise,
   input  wire logic       tb_fall,
   // asynchronous event pin
   input  wire logic       event_pin,
   // output pins
   output logic [5:0]      pwm_out,
   output logic [5:0]      pwm_oe,
   // status
   output logic            module_enabled,
   output logic            load_pending,
   output logic            pushpull_odd
);

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   pwm_out_pkg::stage_s st;
   pwm_out_pkg::stage_s next_st;

   logic       pin_evt;
   logic       period_evt;
   logic       rise_evt;
   logic       fall_evt;
   logic       rdb_start;
   logic       fdb_start;
   logic       rdb_done;
   logic       fdb_done;
   logic       rdb_busy;
   logic       fdb_busy;
   logic       en_now;
   logic [5:0] wave;

   //------------------------------------------------------------
   // event sources
   //------------------------------------------------------------
   assign pin_evt = st.sync2 & ~st.ext_prev;

   pwm_event_select u_sel_period (
      .tb_evt     (tb_period),
      .pin_evt    (pin_evt),
      .source_sel (period_source_reg),
      .evt        (period_evt)
   ); // R13

   pwm_event_select u_sel_rise (
      .tb_evt     (tb_rise),
      .pin_evt    (pin_evt),
      .source_sel (rise_source_reg),
      .evt        (rise_evt)
   ); // R13

   pwm_event_select u_sel_fall (
      .tb_evt     (tb_fall),
      .pin_evt    (pin_evt),
      .source_sel (fall_source_reg),
      .evt        (fall_evt)
   ); // R13

   //------------------------------------------------------------
   // dead band counters
   //------------------------------------------------------------
   pwm_deadband u_db_rise (
      .clk    (clk),
      .rst_n  (rst_n),
      .start  (rdb_start),
      .cancel (fall_evt),
      .len    (st.dbr_act),
      .done   (rdb_done),
      .busy   (rdb_busy)
   ); // R20

   pwm_deadband u_db_fall (
      .clk    (clk),
      .rst_n  (rst_n),
      .start  (fdb_start),
      .cancel (rise_evt),
      .len    (st.dbf_act),
      .done   (fdb_done),
      .busy   (fdb_busy)
   ); // R20

   //------------------------------------------------------------
   // logical waveform to pin mapping
   //------------------------------------------------------------
   function automatic logic [5:0] map_waves(
      input logic [3:0] mode,
      input logic       prim,
      input logic       comp,
      input logic       pa,
      input logic       pb,
      input logic [5:0] steer
   );
      logic [5:0] w;
      w = 6'h00;
      case (mode)
         `MODE_SINGLE: begin
            w = {6{prim}} & steer; // R4 R14
         end
         `MODE_COMPL: begin
            w[`OUT_A] = prim & steer[`OUT_A]; // R17
            w[`OUT_B] = comp & steer[`OUT_B]; // R17
            w[`OUT_C] = prim & steer[`OUT_C]; // R17
            w[`OUT_D] = comp & steer[`OUT_D]; // R17
            w[`OUT_E] = prim & steer[`OUT_E]; // R17
         end
         `MODE_PUSHPULL: begin
            w[`OUT_A] = pa; // R6 R21
            w[`OUT_B] = pb; // R21
         end
         default: begin
            w = 6'h00;
         end
      endcase
      return w;
   endfunction

   assign en_now = main_control_reg[`CTL_EN_BIT];

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      next_st = st;
      rdb_start = 1'b0;
      fdb_start = 1'b0;
      // event pin synchroniser and edge history
      next_st.sync1 = event_pin;
      next_st.sync2 = st.sync1;
      next_st.ext_prev = st.sync2;

      if (ctrl_wr) begin
         next_st.ctl.en = en_now; // R9
         next_st.ctl.rdb_en = main_control_reg[`CTL_RDB_BIT]; // R11
         next_st.ctl.fdb_en = main_control_reg[`CTL_FDB_BIT]; // R11
         next_st.ctl.mode = main_control_reg[`CTL_MODE_MSB:`CTL_MODE_LSB]; // R9 R11
         if (en_now && !st.ctl.en) begin
            next_st.pp_odd = 1'b1; // R25
            next_st.first_per = 1'b1; // R25
         end
         if (main_control_reg[`CTL_LD_BIT]) begin
            if (en_now && !st.ctl.en) begin
               next_st.steer_act = output_steering_reg; // R10
               next_st.dbr_act = rise_deadband_reg; // R10
               next_st.dbf_act = fall_deadband_reg; // R10
               next_st.load_pend = 1'b0;
            end else begin
               next_st.load_pend = 1'b1; // R24
            end
         end
      end

      if (!st.ctl.en) begin
         next_st.prim = 1'b0; // R26
         next_st.comp = 1'b0; // R26
         next_st.pp_a = 1'b0; // R26
         next_st.pp_b = 1'b0; // R26
      end else begin
         if (period_evt) begin
            if (st.load_pend && !(ctrl_wr && main_control_reg[`CTL_LD_BIT])) begin
               next_st.steer_act = output_steering_reg; // R24
               next_st.dbr_act = rise_deadband_reg; // R24
               next_st.dbf_act = fall_deadband_reg; // R24
               next_st.load_pend = 1'b0; // R24
            end
            if (st.first_per) begin
               next_st.first_per = 1'b0; // R25
            end else begin
               next_st.pp_odd = ~st.pp_odd; // R25
            end
         end
         case (st.ctl.mode)
            `MODE_SINGLE: begin
               if (rise_evt) begin
                  next_st.prim = 1'b1; // R15
               end
               if (fall_evt) begin
                  next_st.prim = 1'b0; // R15
               end
            end
            `MODE_COMPL: begin
               if (rdb_done) begin
                  next_st.prim = 1'b1; // R18
               end
               if (fdb_done) begin
                  next_st.comp = 1'b1; // R19
               end
               if (rise_evt) begin
                  next_st.comp = 1'b0; // R18
                  // a fall in the same cycle wins: no rise dead band then
                  if (st.ctl.rdb_en && st.dbr_act != 8'h00 && !fall_evt) begin
                     rdb_start = 1'b1; // R18
                  end else begin
                     next_st.prim = 1'b1; // R16
                  end
               end
               if (fall_evt) begin
                  next_st.prim = 1'b0; // R19
                  if (st.ctl.fdb_en && st.dbf_act != 8'h00) begin
                     fdb_start = 1'b1; // R19
                  end else begin
                     next_st.comp = 1'b1; // R16
                  end
               end
            end
            `MODE_PUSHPULL: begin
               if (rise_evt) begin
                  if (st.pp_odd) begin
                     next_st.pp_a = 1'b1; // R22
                  end else begin
                     next_st.pp_b = 1'b1; // R22
                  end
               end
               if (fall_evt) begin
                  if (st.pp_odd) begin
                     next_st.pp_a = 1'b0; // R22
                  end else begin
                     next_st.pp_b = 1'b0; // R22
                  end
               end
            end
            default: begin
               next_st.prim = 1'b0;
            end
         endcase
      end

      // pin drive: enable gates, polarity flips the active level
      wave = map_waves(st.ctl.mode, st.prim, st.comp, st.pp_a, st.pp_b, st.steer_act); // R8
      next_st.pin_oe = output_enable_reg; // R1 R2 R3
      next_st.pin_out = ((wave & {6{st.ctl.en}}) ^ output_polarity_reg)
                        & output_enable_reg; // R5 R7 R12
   end

   //------------------------------------------------------------
   // registers, all on the module clock
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st; // R23
      end
   end

   assign pwm_out = st.pin_out;
   assign pwm_oe = st.pin_oe;
   assign module_enabled = st.ctl.en;
   assign load_pending = st.load_pend;
   assign pushpull_odd = st.pp_odd;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_enable_follow: assert property ( // R1
      1 |=> pwm_oe == $past(output_enable_reg))
      else $error("output enable does not follow its register");

   chk_undriven_low: assert property ( // R2
      (pwm_out & ~pwm_oe) == 6'h00)
      else $error("disabled pin shows a level");

   chk_disabled_idle: assert property ( // R26
      !st.ctl.en |=> pwm_out == ($past(output_polarity_reg) & $past(output_enable_reg)))
      else $error("disabled module output not at inactive level");

   chk_unsteered_idle: assert property ( // R5
      st.ctl.en && st.ctl.mode == `MODE_SINGLE && !st.steer_act[0] && output_enable_reg[0]
      |=> pwm_out[0] == $past(output_polarity_reg[0]))
      else $error("unsteered output not held inactive");

   chk_prim_after_comp: assert property ( // R18
      st.ctl.mode == `MODE_COMPL && $rose(st.prim) |-> !st.comp)
      else $error("primary asserted while complement active");

   chk_comp_after_prim: assert property ( // R19
      st.ctl.mode == `MODE_COMPL && $rose(st.comp) |-> !st.prim)
      else $error("complement asserted while primary active");

   chk_pp_rise_odd: assert property ( // R22
      st.ctl.en && !ctrl_wr && st.ctl.mode == `MODE_PUSHPULL && rise_evt && !fall_evt
      && st.pp_odd |=> st.pp_a ##1 pwm_out[0] == ($past(output_polarity_reg[0]) ^ 1'b1)
      | !pwm_oe[0])
      else $error("odd period rise did not drive output a");

   chk_pp_toggle: assert property ( // R25
      st.ctl.en && !ctrl_wr && period_evt && !st.first_per |=> st.pp_odd != $past(st.pp_odd))
      else $error("push-pull phase did not toggle");

   chk_load_copy: assert property ( // R24
      st.ctl.en && !ctrl_wr && st.load_pend && period_evt
      |=> st.steer_act == $past(output_steering_reg) && !st.load_pend)
      else $error("buffers not loaded on period event");

   chk_db_exclusive: assert property ( // R18 R19
      !(rdb_busy && fdb_busy))
      else $error("rise and fall dead bands running together");

   cov_single_pulse: cover property (
      st.ctl.mode == `MODE_SINGLE && $rose(st.prim) ##[1:20] $fell(st.prim));
   cov_compl_deadband: cover property (
      st.ctl.mode == `MODE_COMPL && rdb_start ##[1:300] rdb_done);
   cov_pp_both: cover property (
      st.ctl.mode == `MODE_PUSHPULL && $rose(st.pp_a) ##[1:100] $rose(st.pp_b));

endmodule
`default_nettype wire

/* verif/switch_port_model.sv */
// port pin model: a pin follows the stage while driven, else the port latch
`timescale 1ns/1ps
`default_nettype none

module switch_port_model (
   // from the output stage
   input  wire logic [5:0] pwm_out,
   input  wire logic [5:0] pwm_oe,
   // general purpose port latch
   input  wire logic [5:0] gpio,
   // resolved pin levels
   output logic [5:0]      pin
);
   // ------------------------------------------------------------
   // pin resolution
   // ------------------------------------------------------------
   always_comb begin
      pin = (pwm_oe & pwm_out) | (~pwm_oe & gpio);
   end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic       clk;
   logic       rst_n;
   logic       ctrl_wr;
   logic [7:0] ctl;
   logic [5:0] oen;
   logic [5:0] st;
   logic [5:0] pol;
   logic [7:0] dbr;
   logic [7:0] dbf;
   logic [7:0] psrc;
   logic [7:0] rsrc;
   logic [7:0] fsrc;
   logic       tp;
   logic       tr;
   logic       tf;
   logic       evp;
   logic [5:0] gpio;
   logic [5:0] pwm_out;
   logic [5:0] pwm_oe;
   logic [5:0] pin;
   logic       men;
   logic       lpend;
   logic       odd;
   logic [5:0] e;
   int         err_count;
   int         checked;
   int         seed_v;

   pwm_output_stage pwm_output_stage_i (
      .clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .main_control_reg(ctl),
      .output_enable_reg(oen), .output_steering_reg(st), .output_polarity_reg(pol),
      .rise_deadband_reg(dbr), .fall_deadband_reg(dbf), .period_source_reg(psrc),
      .rise_source_reg(rsrc), .fall_source_reg(fsrc), .tb_period(tp), .tb_rise(tr),
      .tb_fall(tf), .event_pin(evp), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
      .module_enabled(men), .load_pending(lpend), .pushpull_odd(odd));

   switch_port_model switch_port_model_i (
      .pwm_out(pwm_out), .pwm_oe(pwm_oe), .gpio(gpio), .pin(pin));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr_ctl(input logic [7:0] v);
      @(posedge clk);
      ctrl_wr <= 1'b1;
      ctl <= v;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      #1;
   endtask

   // which: 0 period, 1 rise, 2 fall; returns w cycles after the taking edge
   task automatic pulse(input int which, input int w);
      @(posedge clk);
      tp <= (which == 0);
      tr <= (which == 1);
      tf <= (which == 2);
      @(posedge clk);
      tp <= 1'b0;
      tr <= 1'b0;
      tf <= 1'b0;
      tick(w);
   endtask

   function automatic logic [5:0] exp_pins(input logic [3:0] m, input logic p, input logic c,
                                           input logic a, input logic b, input logic [5:0] s);
      logic [5:0] w;
      w = 6'h00;
      if (m == 4'h0) w = s & {6{p}};
      if (m == 4'h1) w = s & (({6{p}} & 6'h15) | ({6{c}} & 6'h0a));
      if (m == 4'h2) w = {4'h0, b, a};
      return oen & (pol ^ w);
   endfunction

   // ------------------------------------------------------------
   // clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      ctrl_wr = 1'b0;
      ctl = 8'h00;
      oen = 6'h3b;
      st = 6'h01;
      pol = 6'h05;
      dbr = 8'h03;
      dbf = 8'h05;
      psrc = 8'h01;
      rsrc = 8'h01;
      fsrc = 8'h01;
      tp = 1'b0;
      tr = 1'b0;
      tf = 1'b0;
      evp = 1'b0;
      gpio = 6'h2a;
      err_count = 0;
      checked = 0;
      seed_v = $urandom(22355);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      check("oe after reset", pwm_oe, oen);
      check("out after reset", pwm_out, exp_pins(4'hf, 1'b0, 1'b0, 1'b0, 1'b0, st));
      check("enabled after reset", {5'h00, men}, 6'h00);
      // single mode with random enables, steering and polarity
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         oen <= 6'($urandom);
         st <= (i == 0) ? 6'h03 : 6'($urandom);
         pol <= 6'($urandom);
         wr_ctl(8'h00);
         wr_ctl(8'hc0);
         check("enabled", {5'h00, men}, 6'h01);
         pulse(1, 2);
         e = exp_pins(4'h0, 1'b1, 1'b0, 1'b0, 1'b0, st);
         check("single rise", pwm_out, e);
         check("oe", pwm_oe, oen);
         check("pin level", pin, (oen & e) | (~oen & gpio));
         pulse(2, 2);
         check("single fall", pwm_out, exp_pins(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, st));
      end
      // events are ignored while the module is disabled
      wr_ctl(8'h40);
      pulse(1, 2);
      check("disabled rise", pwm_out, exp_pins(4'hf, 1'b0, 1'b0, 1'b0, 1'b0, st));
      // push-pull ignores steering and alternates a and b
      @(posedge clk);
      oen <= 6'h3f;
      st <= 6'h00;
      pol <= 6'h02;
      wr_ctl(8'h00);
      wr_ctl(8'hc2);
      for (int k = 0; k < 4; k++) begin
         pulse(0, 2);
         check("phase", {5'h00, odd}, {5'h00, ~k[0]});
         pulse(1, 2);
         check("pp rise", pwm_out, exp_pins(4'h2, 1'b0, 1'b0, ~k[0], k[0], st));
         pulse(2, 2);
         check("pp fall", pwm_out, exp_pins(4'h2, 1'b0, 1'b0, 1'b0, 1'b0, st));
      end
      // complementary with dead bands of 3 and 5 cycles
      @(posedge clk);
      st <= 6'h3f;
      pol <= 6'h00;
      wr_ctl(8'h00);
      wr_ctl(8'hf1);
      pulse(2, 2);
      check("fall primary off", pwm_out, 6'h00);
      tick(4);
      check("fall dead band", pwm_out, 6'h00);
      tick(1);
      check("fall comp on", pwm_out, 6'h0a);
      pulse(1, 2);
      check("rise comp off", pwm_out, 6'h00);
      tick(2);
      check("rise dead band", pwm_out, 6'h00);
      tick(1);
      check("rise primary on", pwm_out, 6'h15);
      // complementary without dead bands switches both at once
      wr_ctl(8'h00);
      wr_ctl(8'hc1);
      pulse(1, 2);
      check("nodb rise", pwm_out, 6'h15);
      pulse(2, 2);
      check("nodb fall", pwm_out, 6'h0a);
      // an undefined mode code keeps every enabled output inactive
      wr_ctl(8'h83);
      pulse(1, 2);
      check("undefined mode idle", pwm_out, 6'h00);
      // a load while enabled waits for the next period event
      @(posedge clk);
      st <= 6'h01;
      wr_ctl(8'h00);
      wr_ctl(8'hc0);
      check("load on enable", {5'h00, lpend}, 6'h00);
      @(posedge clk);
      st <= 6'h30;
      wr_ctl(8'hc0);
      check("load pending", {5'h00, lpend}, 6'h01);
      pulse(1, 2);
      check("old steering", pwm_out, 6'h01);
      pulse(0, 0);
      for (int n = 0; n < 5 && lpend !== 1'b0; n++) tick(1);
      if (lpend !== 1'b0) begin
         err_count++;
         give_verdict();
      end
      pulse(1, 2);
      check("new steering", pwm_out, 6'h30);
      // rise taken from the event pin only
      @(posedge clk);
      rsrc <= 8'h02;
      pulse(2, 2);
      pulse(1, 2);
      check("rise source masked", pwm_out, 6'h00);
      @(posedge clk);
      evp <= 1'b1;
      tick(7);
      check("pin rise event", pwm_out, 6'h30);
      @(posedge clk);
      evp <= 1'b0;
      tick(2);
      give_verdict();
   end
endmodule
`default_nettype wire
